// ---- verilog/node_address_cfg.svh ----
// timing, code and reset constants for the node address selector
`ifndef NODE_ADDRESS_CFG_SVH
`define NODE_ADDRESS_CFG_SVH
`define CLK_FREQ_HZ        50000000
`define BLINK_PERIOD_MS    1000
`define BLINK_HALF_CYCLES  ((`CLK_FREQ_HZ / 1000) * `BLINK_PERIOD_MS / 2)
`define INIT_TIME_US       100
`define INIT_CYCLES        ((`CLK_FREQ_HZ / 1000000) * `INIT_TIME_US)
`define ADDR_UNSET         8'hff
`define HIGH_WEIGHT_SHIFT  6
`define MID_WEIGHT_SHIFT   3
`define ALIAS_RESET        16'h0000
`define REG_ADDR_CTRL      4'h0
`define REG_ADDR_STATUS    4'h1
`define REG_ADDR_IRQ_STAT  4'h2
`define REG_ADDR_IRQ_MASK  4'h3
`define REG_ADDR_ALIAS     4'h4
`define IRQ_BIT_READY      0
`define IRQ_BIT_ERROR      1
`define IRQ_BIT_INACTIVE   2
`endif

// ---- verilog/node_address_pkg.sv ----
// types shared by the node address selector
`default_nettype none
package node_address_pkg;
    typedef enum logic [3:0]
    {
        ST_SAMPLE = 4'b0001,
        ST_INIT   = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_FAULT  = 4'b1000
    } phase_t;
    typedef enum logic
    {
        PROTO_OPEN_CAN   = 1'b0,
        PROTO_PROPRIETARY = 1'b1
    } proto_t;
endpackage
`default_nettype wire

// ---- verilog/strap_code_if.sv ----
// carries a synchronised strap level vector and its decoded 3-bit code
`default_nettype none
interface strap_code_if;
    logic [6:0] level;
    logic [2:0] code;
    modport decoder (input level, output code);
    modport user    (output level, input code);
endinterface
`default_nettype wire

// ---- verilog/strap_band_decoder.sv ----
// thermometer-to-code decoder for one voltage-banded strap pin
`default_nettype none
module strap_band_decoder
(
    strap_code_if.decoder bus
);
    // code is one plus the highest comparator output above threshold; bands ascend so for a thermometer level this equals the count
    always_comb
    begin
        bus.code = 3'h0;
        for (int i = 0; i < 7; i++)
        begin
            if (bus.level[i])
                bus.code = 3'(i + 1);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/node_address_select.sv ----
// node address and protocol selection with status indicators and register port
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "node_address_cfg.svh"
`default_nettype none
module node_address_select
    import node_address_pkg::*;
#(
    parameter int BLINK_HALF = `BLINK_HALF_CYCLES,
    parameter int INIT_LEN   = `INIT_CYCLES
)
(
    input  wire logic        MCLK,
    input  wire logic        SRST,
    input  wire logic        VARIANT_SWITCH,
    input  wire logic [6:0]  STRAP_LOW_LEVEL,
    input  wire logic [6:0]  STRAP_MID_LEVEL,
    input  wire logic [6:0]  STRAP_HIGH_LEVEL,
    input  wire logic [5:0]  CONFIG_SWITCH_BANK,
    input  wire logic        ERROR_IN,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic      [7:0]  NODE_ADDRESS,
    output logic             PROPRIETARY_CAN_PROTOCOL,
    output logic             LSS_INACTIVE,
    output logic      [15:0] STATION_ALIAS,
    output logic             READY_INDICATOR,
    output logic             ERROR_INDICATOR,
    output logic             IRQ
);
    localparam int BW = $clog2(BLINK_HALF + 1);
    localparam int IW = $clog2(INIT_LEN + 1);

    // two-stage synchronisers for every strap, switch and error input
    // pins move freely against MCLK, so only the second stage feeds logic
    logic [6:0]  low_s1_reg;
    logic [6:0]  low_s2_reg;
    logic [6:0]  mid_s1_reg;
    logic [6:0]  mid_s2_reg;
    logic [6:0]  high_s1_reg;
    logic [6:0]  high_s2_reg;
    logic [5:0]  sw_s1_reg;
    logic [5:0]  sw_s2_reg;
    logic        var_s1_reg;
    logic        var_s2_reg;
    logic        err_s1_reg;
    logic        err_s2_reg;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            low_s1_reg  <= 7'h00;
            low_s2_reg  <= 7'h00;
            mid_s1_reg  <= 7'h00;
            mid_s2_reg  <= 7'h00;
            high_s1_reg <= 7'h00;
            high_s2_reg <= 7'h00;
            sw_s1_reg   <= 6'h00;
            sw_s2_reg   <= 6'h00;
            var_s1_reg  <= 1'b0;
            var_s2_reg  <= 1'b0;
            err_s1_reg  <= 1'b0;
            err_s2_reg  <= 1'b0;
        end
        else
        begin
            low_s1_reg  <= STRAP_LOW_LEVEL;
            low_s2_reg  <= low_s1_reg;
            mid_s1_reg  <= STRAP_MID_LEVEL;
            mid_s2_reg  <= mid_s1_reg;
            high_s1_reg <= STRAP_HIGH_LEVEL;
            high_s2_reg <= high_s1_reg;
            sw_s1_reg   <= CONFIG_SWITCH_BANK;
            sw_s2_reg   <= sw_s1_reg;
            var_s1_reg  <= VARIANT_SWITCH;
            var_s2_reg  <= var_s1_reg;
            err_s1_reg  <= ERROR_IN;
            err_s2_reg  <= err_s1_reg;
        end
    end

    // one banded decoder per strap pin
    strap_code_if low_if ();
    strap_code_if mid_if ();
    strap_code_if high_if ();
    assign low_if.level  = low_s2_reg;
    assign mid_if.level  = mid_s2_reg;
    assign high_if.level = high_s2_reg;
    strap_band_decoder u_low  (.bus(low_if));
    strap_band_decoder u_mid  (.bus(mid_if));
    strap_band_decoder u_high (.bus(high_if));

    // candidate address from the strap codes or from the switch bank
    logic [7:0] strap_addr;
    logic [7:0] switch_addr;
    logic [7:0] cand_addr;
    logic       cand_proto;
    logic       straps_open;
    always_comb
    begin
        straps_open = (low_if.code == 3'h0) && (mid_if.code == 3'h0) && (high_if.code == 3'h0);
        // top bit of the high code is dropped so the result fits eight bits
        strap_addr  = {high_if.code[1:0], 6'h00} + {2'h0, mid_if.code, 3'h0} + {5'h00, low_if.code};
        if (straps_open)
            strap_addr = `ADDR_UNSET;
        switch_addr = {3'h0, sw_s2_reg[4:0]};
        // all five address switches off would mean address zero, so it reads as unset whatever bit 5 holds
        if (sw_s2_reg[4:0] == 5'h00)
            switch_addr = `ADDR_UNSET;
        cand_addr  = var_s2_reg ? switch_addr : strap_addr;
        // strap variant has no protocol switch; default to the open protocol
        cand_proto = var_s2_reg & sw_s2_reg[5];
    end

    // phase machine: settle synchronisers, latch, init delay, then run
    phase_t          phase_reg;
    phase_t          phase_next;
    logic [1:0]      settle_reg;
    logic [1:0]      settle_next;
    logic [IW-1:0]   init_cnt_reg;
    logic [IW-1:0]   init_cnt_next;
    logic [7:0]      addr_reg;
    logic [7:0]      addr_next;
    logic            proto_reg;
    logic            proto_next;
    logic [15:0]     alias_reg;
    logic [15:0]     alias_next;
    logic            alias_lock_reg;
    logic            alias_lock_next;
    logic            alias_wr;
    always_comb
    begin
        phase_next    = phase_reg;
        settle_next   = settle_reg;
        init_cnt_next = init_cnt_reg;
        addr_next     = addr_reg;
        proto_next    = proto_reg;
        alias_next    = alias_reg;
        alias_lock_next = alias_lock_reg;
        case (phase_reg)
            ST_SAMPLE:
            begin
                // wait for the pin levels to pass both synchroniser stages
                settle_next = settle_reg + 2'h1;
                if (settle_reg == 2'h3)
                begin
                    addr_next  = cand_addr;
                    proto_next = cand_proto;
                    // lock decided once here so later pin moves cannot unlock it
                    alias_lock_next = !var_s2_reg && straps_open;
                    if (!var_s2_reg && straps_open)
                        alias_next = `ALIAS_RESET;
                    phase_next = ST_INIT;
                end
            end
            ST_INIT:
            begin
                // fixed start-up delay before the green lamp may light
                init_cnt_next = init_cnt_reg + IW'(1);
                if (init_cnt_reg == IW'(INIT_LEN - 1))
                    phase_next = ST_RUN;
            end
            ST_RUN:
            begin
                // an error already present during init is caught on the first run cycle
                if (err_s2_reg)
                    phase_next = ST_FAULT;
            end
            ST_FAULT:
            begin
                // error clears only by reset; address stays latched
                phase_next = ST_FAULT;
            end
            default:
            begin
                phase_next = ST_SAMPLE;
            end
        endcase
        // alias writes are refused while sampling and while forced to zero
        if (alias_wr && phase_reg != ST_SAMPLE && !alias_lock_reg)
            alias_next = REG_WDATA[15:0];
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            phase_reg    <= ST_SAMPLE;
            settle_reg   <= 2'h0;
            init_cnt_reg <= '0;
            addr_reg     <= `ADDR_UNSET;
            proto_reg    <= 1'b0;
            alias_reg    <= `ALIAS_RESET;
            alias_lock_reg <= 1'b0;
        end
        else
        begin
            phase_reg    <= phase_next;
            settle_reg   <= settle_next;
            init_cnt_reg <= init_cnt_next;
            addr_reg     <= addr_next;
            proto_reg    <= proto_next;
            alias_reg    <= alias_next;
            alias_lock_reg <= alias_lock_next;
        end
    end

    // inactive state flag and the one-second blink for the green indicator
    // counter parks at zero so every inactive entry starts with a dark half
    logic          inactive;
    logic [BW-1:0] blink_cnt_reg;
    logic [BW-1:0] blink_cnt_next;
    logic          blink_reg;
    logic          blink_next;
    assign inactive = (phase_reg == ST_RUN) && !proto_reg && (addr_reg == `ADDR_UNSET);
    always_comb
    begin
        blink_cnt_next = '0;
        blink_next     = 1'b0;
        if (inactive)
        begin
            blink_cnt_next = blink_cnt_reg + BW'(1);
            blink_next     = blink_reg;
            if (blink_cnt_reg == BW'(BLINK_HALF - 1))
            begin
                blink_cnt_next = '0;
                blink_next     = !blink_reg;
            end
        end
    end

    // indicator drive; fault forces green off and red on
    // both lamps are registered so they switch on the same edge
    logic ready_next;
    logic error_next;
    logic ready_reg;
    logic error_reg;
    always_comb
    begin
        error_next = (phase_reg == ST_FAULT) || (phase_reg == ST_RUN && err_s2_reg);
        ready_next = 1'b0;
        if (phase_reg == ST_RUN && !err_s2_reg)
            ready_next = inactive ? blink_reg : 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
            ready_reg     <= 1'b0;
            error_reg     <= 1'b0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg     <= blink_next;
            ready_reg     <= ready_next;
            error_reg     <= error_next;
        end
    end

    // sticky events: ready reached, error entered, inactive entered
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_stat_next;
    logic [2:0]  irq_mask_reg;
    logic [2:0]  irq_mask_next;
    logic [2:0]  events;
    logic        inactive_d_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    assign alias_wr = REG_WR && (REG_ADDR == `REG_ADDR_ALIAS);
    always_comb
    begin
        events = 3'h0;
        events[`IRQ_BIT_READY]    = (phase_reg == ST_INIT) && (phase_next == ST_RUN);
        events[`IRQ_BIT_ERROR]    = (phase_reg == ST_RUN) && (phase_next == ST_FAULT);
        events[`IRQ_BIT_INACTIVE] = inactive && !inactive_d_reg;
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        // a set in the same cycle as a write-one clear still lands
        if (REG_WR && REG_ADDR == `REG_ADDR_IRQ_STAT)
            irq_stat_next = irq_stat_reg & ~REG_WDATA[2:0];
        irq_stat_next = irq_stat_next | events;
        if (REG_WR && REG_ADDR == `REG_ADDR_IRQ_MASK)
            irq_mask_next = REG_WDATA[2:0];
        // idle read data is zero so a late sample never sees a stale word
        rdata_next = 32'h0000_0000;
        if (REG_RD)
        begin
            case (REG_ADDR)
                `REG_ADDR_CTRL:     rdata_next = {23'h0, proto_reg, addr_reg};
                `REG_ADDR_STATUS:   rdata_next = {25'h0, phase_reg, inactive, error_reg, ready_reg};
                `REG_ADDR_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
                `REG_ADDR_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
                `REG_ADDR_ALIAS:    rdata_next = {16'h0, alias_reg};
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            irq_stat_reg   <= 3'h0;
            irq_mask_reg   <= 3'h0;
            inactive_d_reg <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
        end
        else
        begin
            irq_stat_reg   <= irq_stat_next;
            irq_mask_reg   <= irq_mask_next;
            inactive_d_reg <= inactive;
            rdata_reg      <= rdata_next;
        end
    end

    // outputs; irq is a plain level that drops once status is cleared or masked
    assign REG_RDATA                = rdata_reg;
    assign NODE_ADDRESS             = addr_reg;
    assign PROPRIETARY_CAN_PROTOCOL = proto_reg;
    assign LSS_INACTIVE             = inactive;
    assign STATION_ALIAS            = alias_reg;
    assign READY_INDICATOR          = ready_reg;
    assign ERROR_INDICATOR          = error_reg;
    assign IRQ                      = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ---- tb/strap_board_model.sv ----
// board straps and switches seen by the selector
`default_nettype none
module strap_board_model
(
    input  wire logic [2:0] lo_code,
    input  wire logic [2:0] mid_code,
    input  wire logic [2:0] hi_code,
    input  wire logic [5:0] sw_on,
    output logic      [6:0] lo_lvl,
    output logic      [6:0] mid_lvl,
    output logic      [6:0] hi_lvl,
    output logic      [5:0] sw_bank
);
    timeunit 1ns;
    timeprecision 1ns;
    // code n lights the n lowest band comparators
    assign lo_lvl  = 7'h7f >> (3'h7 - lo_code);
    assign mid_lvl = 7'h7f >> (3'h7 - mid_code);
    assign hi_lvl  = 7'h7f >> (3'h7 - hi_code);
    // switches are static levels, ON reads as one
    assign sw_bank = sw_on;
endmodule
`default_nettype wire

// ---- tb/node_address_select_props.sv ----
// port assertions for the node address selector
`default_nettype none
module node_address_select_props
#(
    parameter int BLINK_HALF = 10
)
(
    input wire logic        MCLK,
    input wire logic        SRST,
    input wire logic        VARIANT_SWITCH,
    input wire logic        ERROR_IN,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [7:0]  NODE_ADDRESS,
    input wire logic        PROPRIETARY_CAN_PROTOCOL,
    input wire logic        LSS_INACTIVE,
    input wire logic [15:0] STATION_ALIAS,
    input wire logic        READY_INDICATOR,
    input wire logic        ERROR_INDICATOR
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    logic [31:0] gap_reg;
    logic        prev_reg;
    logic        seen_reg;
    // cycles since last green toggle; first toggle only arms it
    always_ff @(posedge MCLK)
    begin
        prev_reg <= READY_INDICATOR;
        if (SRST || !LSS_INACTIVE)
        begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
        end
        else if (READY_INDICATOR != prev_reg)
        begin
            gap_reg  <= '0;
            seen_reg <= 1'b1;
        end
        else
            gap_reg <= gap_reg + 1;
    end
    sequence err_held;
        ERROR_IN && READY_INDICATOR ##1 ERROR_IN;
    endsequence
    sequence green_flip;
        seen_reg && READY_INDICATOR != prev_reg;
    endsequence
    a_red_follows: assert property (err_held |-> ##[0:4] ERROR_INDICATOR)
        else $error("red late");
    a_red_sticky: assert property (ERROR_INDICATOR |=> ERROR_INDICATOR)
        else $error("red dropped");
    a_green_off: assert property (ERROR_INDICATOR |-> !READY_INDICATOR)
        else $error("green on error");
    a_addr_hold: assert property (NODE_ADDRESS != 8'hff || READY_INDICATOR || ERROR_INDICATOR |=> $stable(NODE_ADDRESS))
        else $error("address moved");
    a_proto_hold: assert property (PROPRIETARY_CAN_PROTOCOL || READY_INDICATOR || ERROR_INDICATOR
        |=> $stable(PROPRIETARY_CAN_PROTOCOL))
        else $error("protocol moved");
    a_lss_cause: assert property (LSS_INACTIVE |-> NODE_ADDRESS == 8'hff && !PROPRIETARY_CAN_PROTOCOL)
        else $error("inactive wrong");
    a_switch_range: assert property (VARIANT_SWITCH && NODE_ADDRESS != 8'hff |-> NODE_ADDRESS <= 8'h1f)
        else $error("switch address range");
    a_alias_open: assert property (!VARIANT_SWITCH && NODE_ADDRESS == 8'hff |-> STATION_ALIAS == 16'h0)
        else $error("alias not zero");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data stray");
    a_blink_rate: assert property (green_flip |-> gap_reg == BLINK_HALF - 1)
        else $error("blink period");
endmodule
bind node_address_select node_address_select_props #(.BLINK_HALF(BLINK_HALF)) u_props
(
    .MCLK(MCLK),
    .SRST(SRST),
    .VARIANT_SWITCH(VARIANT_SWITCH),
    .ERROR_IN(ERROR_IN),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .NODE_ADDRESS(NODE_ADDRESS),
    .PROPRIETARY_CAN_PROTOCOL(PROPRIETARY_CAN_PROTOCOL),
    .LSS_INACTIVE(LSS_INACTIVE),
    .STATION_ALIAS(STATION_ALIAS),
    .READY_INDICATOR(READY_INDICATOR),
    .ERROR_INDICATOR(ERROR_INDICATOR)
);
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the node address selector
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, srst, variant, err_in, reg_wr, reg_rd;
    logic        proto, lss, ready, red, irq;
    logic [2:0]  lo_code, mid_code, hi_code;
    logic [5:0]  sw_on, sw_bank;
    logic [6:0]  lo_lvl, mid_lvl, hi_lvl;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, rdata, rv;
    logic [7:0]  node_addr;
    logic [15:0] alias_id;
    int          errors, check_count, n;
    strap_board_model board
    (
        .lo_code(lo_code), .mid_code(mid_code), .hi_code(hi_code), .sw_on(sw_on),
        .lo_lvl(lo_lvl), .mid_lvl(mid_lvl), .hi_lvl(hi_lvl), .sw_bank(sw_bank)
    );
    // short blink and init keep the run brief
    node_address_select #(.BLINK_HALF(10), .INIT_LEN(4)) uut
    (
        .MCLK(mclk), .SRST(srst), .VARIANT_SWITCH(variant), .STRAP_LOW_LEVEL(lo_lvl),
        .STRAP_MID_LEVEL(mid_lvl), .STRAP_HIGH_LEVEL(hi_lvl), .CONFIG_SWITCH_BANK(sw_bank),
        .ERROR_IN(err_in), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata), .NODE_ADDRESS(node_addr), .PROPRIETARY_CAN_PROTOCOL(proto),
        .LSS_INACTIVE(lss), .STATION_ALIAS(alias_id), .READY_INDICATOR(ready),
        .ERROR_INDICATOR(red), .IRQ(irq)
    );
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // pins settle under reset, then wait for green
    task automatic boot(input logic v, input logic [8:0] c, input logic [5:0] s);
        @(posedge mclk);
        srst    <= 1'b1;
        err_in  <= 1'b0;
        variant <= v;
        {hi_code, mid_code, lo_code} <= c;
        sw_on   <= s;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        #1;
        for (n = 0; n < 40 && ready !== 1'b1; n++) #20;
        chk("boot green", 32'h1, ready);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rv = rdata;
    endtask
    // weighted strap codes, high code bit two dropped
    task automatic t_straps();
        logic [8:0] tbl [4];
        tbl = '{9'h15e, 9'h1c1, 9'h0fe, 9'h102};
        foreach (tbl[i])
        begin
            boot(1'b0, tbl[i], 6'h3f);
            rd(4'h0);
            chk("ctrl", 32'(64 * tbl[i][7:6] + 8 * tbl[i][5:3] + tbl[i][2:0]), rv);
        end
        wr(4'h4, 32'h1234abcd);
        rd(4'h4);
        chk("alias", 32'h0000abcd, rv);
        chk("alias pin", 16'habcd, alias_id);
    endtask
    // strap moves after the latch must not unlock the alias or move the address
    task automatic t_open();
        boot(1'b0, 9'h000, 6'h00);
        @(posedge mclk);
        lo_code <= 3'h5;
        repeat (2) @(posedge mclk);
        wr(4'h4, 32'h0000beef);
        rd(4'h4);
        chk("alias", 32'h0, rv);
        rd(4'h1);
        chk("status", 32'h25, rv);
        rd(4'h2);
        chk("stat inactive", 32'h5, rv);
        chk("addr", 8'hff, node_addr);
        chk("lss", 1'b1, lss);
    endtask
    // switch moves after the latch must not show
    task automatic t_switch();
        boot(1'b1, 9'h1ff, 6'h35);
        @(posedge mclk);
        sw_on <= 6'h0a;
        repeat (10) @(posedge mclk);
        #1;
        chk("addr", 8'h15, node_addr);
        chk("proto", 1'b1, proto);
        boot(1'b1, 9'h000, 6'h1f);
        chk("addr", 8'h1f, node_addr);
        chk("proto", 1'b0, proto);
    endtask
    task automatic t_unset();
        boot(1'b1, 9'h000, 6'h00);
        chk("addr", 8'hff, node_addr);
        chk("lss", 1'b1, lss);
        for (n = 0; n < 40 && ready === 1'b1; n++) #20;
        chk("blink high", 32'h0000000a, n);
        for (n = 0; n < 40 && ready !== 1'b1; n++) #20;
        chk("blink low", 32'h0000000a, n);
        boot(1'b1, 9'h000, 6'h20);
        chk("lss", 1'b0, lss);
        chk("green", 1'b1, ready);
    endtask
    task automatic t_error();
        boot(1'b0, 9'h053, 6'h00);
        chk("green", 1'b1, ready);
        wr(4'h3, 32'h1);
        rd(4'h2);
        chk("stat", 32'h1, rv);
        chk("irq", 1'b1, irq);
        wr(4'h2, 32'h1);
        rd(4'h2);
        chk("stat clr", 32'h0, rv);
        chk("irq off", 1'b0, irq);
        wr(4'h3, 32'h0);
        @(posedge mclk);
        err_in <= 1'b1;
        #1;
        for (n = 0; n < 10 && red !== 1'b1; n++) #20;
        chk("red", 1'b1, red);
        chk("green", 1'b0, ready);
        rd(4'h2);
        chk("stat err", 32'h2, rv);
        chk("irq masked", 1'b0, irq);
        wr(4'h3, 32'h2);
        rd(4'hf);
        chk("unmapped", 32'h0, rv);
        chk("irq err", 1'b1, irq);
    endtask
    task automatic summarize();
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        {srst, variant, err_in, reg_wr, reg_rd} = 5'h10;
        {reg_addr, reg_wdata, hi_code, mid_code, lo_code, sw_on} = '0;
        errors = 0;
        check_count = 0;
        t_straps();
        t_open();
        t_switch();
        t_unset();
        t_error();
        summarize();
    end
    // whole run is well under a thousand cycles
    initial
    begin
        #200000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
